// File: rsa_host_model.sv
// Purpose: host controller model, master of the serial link
// Assumes: mode 0, msb first, 15 ns serial period
// Notes: serial clock stands still outside frames
`timescale 1ns/1ps
module rsa_host_model (
  output logic serial_clk, // serial clock to the device
  output logic serial_select_low, // select, active low
  output logic serial_in, // data to the device
  input wire logic serial_out, // data from the device
  input wire logic serial_out_oe // device drives serial_out
);
  // idle: deselected, clock low
  initial begin
    serial_clk = 1'b0;
    serial_select_low = 1'b1;
    serial_in = 1'b0;
  end
  // open a frame, select set up well before the first rise
  task automatic sel();
    serial_select_low = 1'b0;
    #30;
  endtask
  // deselecting is the only way a buffer or ram access ends
  task automatic desel();
    #30;
    serial_select_low = 1'b1;
    serial_in = ~serial_in; // released line never shows a stale bit
    #40;
  endtask
  // one byte each way: data set while low, both sides sample on rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      #7.5;
      serial_clk = 1'b1;
      rx[i] = serial_out_oe ? serial_out : 1'bz;
      #7.5;
      serial_clk = 1'b0;
    end
  endtask
endmodule // rsa_host_model

// File: rsa_pkg.sv
// Purpose: shared constants and types of the radio serial access block
// Assumes: serial link is mode 0, msb first, bytes framed by the select line
// Notes: ram map, port addresses, strobe codes and decode field positions
package rsa_pkg;

  // on-chip ram size and bank layout
  localparam int RSA_RAM_BYTES = 368; // three banks: 128 + 128 + 112
  localparam int RSA_BUF_BYTES = 128; // depth of each buffer bank
  localparam logic [8:0] RSA_TXBUF_BASE = 9'h000; // transmit buffer storage
  localparam logic [8:0] RSA_TXBUF_LAST = 9'h07f;
  localparam logic [8:0] RSA_RXBUF_BASE = 9'h080; // receive buffer storage
  localparam logic [8:0] RSA_RXBUF_LAST = 9'h0ff;
  localparam logic [8:0] RSA_KEY0_BASE = 9'h100; // cipher_key_zero
  localparam logic [8:0] RSA_RECEIVE_NONCE_BASE = 9'h110; // receive_nonce / receive_counter
  localparam logic [8:0] RSA_STANDALONE_CIPHER_BUFFER_BASE = 9'h120; // standalone_cipher_buffer
  localparam logic [8:0] RSA_CIPHER_KEY_ONE_BASE = 9'h130; // cipher_key_one
  localparam logic [8:0] RSA_TRANSMIT_NONCE_BASE = 9'h140; // transmit_nonce, flags byte at 0x14f
  localparam logic [8:0] RSA_CHAIN_BASE = 9'h150; // auth_chain_state scratch
  localparam logic [8:0] RSA_EXTADDR_BASE = 9'h160; // extended_node_address, lsb first
  localparam logic [8:0] RSA_NETID_BASE = 9'h168; // network_identifier, lsb first
  localparam logic [8:0] RSA_SHORTADDR_BASE = 9'h16a; // short_node_address, lsb first
  localparam logic [8:0] RSA_RAM_LAST = 9'h16f; // last implemented byte

  // register-space addresses
  localparam logic [5:0] RSA_TXPORT_ADDR = 6'h3e; // transmit_buffer_port
  localparam logic [5:0] RSA_RXPORT_ADDR = 6'h3f; // receive_buffer_port
  localparam logic [5:0] RSA_STROBE_LAST = 6'h0e; // strobes are 0x00..0x0e
  localparam logic [5:0] RSA_FLUSH_RX_CODE = 6'h0a; // receive_flush_strobe
  localparam logic [5:0] RSA_FLUSH_TX_CODE = 6'h0b; // transmit_flush_strobe

  // decode field positions
  localparam int RSA_AB_RAM_BIT = 7; // first byte: ram / register select
  localparam int RSA_AB_RD_BIT = 6; // first byte: 1 = read
  localparam int RSA_BANK_HI = 7; // second ram byte: ram_bank_select msb
  localparam int RSA_BANK_LO = 6; // second ram byte: ram_bank_select lsb
  localparam int RSA_RAM_RO_BIT = 5; // second ram byte: 1 = read only

  // decoder phases, one per kind of byte expected next
  typedef enum logic [2:0] {
    PH_ADDR     = 3'b000,
    PH_REG_HI   = 3'b001,
    PH_REG_LO   = 3'b010,
    PH_RAM_HI   = 3'b011,
    PH_RAM_DATA = 3'b100,
    PH_TXBUF    = 3'b101,
    PH_RXBUF    = 3'b110
  } rsa_phase_e;

  // radio core levels seen by the status byte
  typedef struct packed {
    logic xosc_stable; // crystal oscillator running
    logic enc_busy; // cipher engine busy
    logic tx_active; // transmission in progress
    logic pll_lock; // synthesizer locked
    logic rssi_valid; // signal strength valid
  } rsa_radio_s;

  // status byte bits 6..1, bit 7 and bit 0 read zero
  typedef struct packed {
    logic xosc_stable;
    logic tx_underflow;
    logic enc_busy;
    logic tx_active;
    logic pll_lock;
    logic rssi_valid;
  } rsa_stat_s;

  // committed strobe or register write handed to the core clock
  typedef struct packed {
    logic is_strobe; // 1 = strobe, 0 = register write
    logic [5:0] addr; // strobe code or register address
    logic [15:0] data; // register write data, msb byte first on the wire
  } rsa_cmd_s;

endpackage

// File: rsa_serial_access.sv
// Purpose: serial slave access layer: strobes, registers, buffer ports, ram
// Assumes: host drives serial_clk low at idle, data sampled on rising edges
// Notes: serial side runs on serial_clk, handoff to ref_clk by toggle sync
`timescale 1ns/1ps

module rsa_serial_access
  import rsa_pkg::*;
#(
  parameter logic [7:0] RX_THRESHOLD = 8'h40 // receive count above this raises threshold pin
) (
  input wire logic ref_clk, // core clock, 100 mhz
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic serial_clk, // serial clock from the host
  input wire logic serial_select_low, // chip select from the host, active low
  input wire logic serial_in, // serial data from the host
  output logic serial_out, // serial data to the host
  output logic serial_out_oe, // high while serial_out is driven
  input wire rsa_radio_s radio_in, // radio core status levels
  input wire logic tx_underflow_evt, // one-cycle pulse: transmit buffer ran dry
  output logic strobe_pulse, // one-cycle pulse: strobe executed
  output logic [5:0] strobe_code, // code of the last strobe
  output logic reg_wr_pulse, // one-cycle pulse: register write committed
  output logic [5:0] reg_addr, // address of the last register write
  output logic [15:0] reg_wdata, // data of the last register write
  output logic tx_underflow, // sticky underflow flag
  output logic rx_avail_pin, // receive buffer holds data
  output logic rx_threshold_pin // receive buffer count above threshold
);

  // ------------------------------------------------------------ serial domain
  // frame reset: ends every access the moment select rises; a glitch on
  // select would also clear the decoder, which is the safe outcome
  logic frame_rst_n;
  assign frame_rst_n = rst_n & ~serial_select_low;

  logic [7:0] sh_q; // incoming shift register
  logic [2:0] cnt_q; // bit position within the byte
  logic got_q; // a whole byte sits in sh_q

  // capture host data on rising edges, msb first
  always_ff @(posedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sh_q <= 8'h00;
      cnt_q <= 3'h0;
      got_q <= 1'b0;
    end else begin
      sh_q <= {sh_q[6:0], serial_in};
      cnt_q <= cnt_q + 3'h1;
      got_q <= (cnt_q == 3'h7);
    end
  end

  // status levels cross into the serial clock through three flops;
  // serial_clk only runs in frames, so values may be a few edges old
  logic tx_underflow_q; // sticky underflow flag, core domain, read here through the sync
  rsa_stat_s stat_raw, st_s1_q, st_s2_q, st_s3_q, stat_q;
  assign stat_raw = '{xosc_stable: radio_in.xosc_stable, tx_underflow: tx_underflow_q,
                      enc_busy: radio_in.enc_busy, tx_active: radio_in.tx_active,
                      pll_lock: radio_in.pll_lock, rssi_valid: radio_in.rssi_valid};

  always_ff @(posedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_s1_q <= '0;
      st_s2_q <= '0;
      st_s3_q <= '0;
      stat_q <= '0;
    end else begin
      st_s1_q <= stat_raw;
      st_s2_q <= st_s1_q;
      st_s3_q <= st_s2_q;
      if (st_s2_q == st_s3_q) begin // accept only a settled value
        stat_q <= st_s3_q;
      end
    end
  end

  logic [7:0] stat_byte; // reserved bits 7 and 0 read zero
  assign stat_byte = {1'b0, stat_q, 1'b0};

  // frame-scoped decoder state
  rsa_phase_e ph_q, ph_d; // what the next byte means
  logic [7:0] out_q; // outgoing shift register
  logic so_q; // bit on the serial output
  logic [8:0] raddr_q, raddr_d; // ram byte address
  logic [7:0] hi_q, hi_d; // register msb byte
  logic [5:0] regaddr_q, regaddr_d; // register being accessed
  logic rd_q, rd_d; // access is a read
  logic ro_q, ro_d; // ram access is read only

  // persistent storage and buffer pointers
  logic [7:0] ram_q [0:RSA_RAM_BYTES-1]; // ram, flops addressed by byte index
  logic [7:0] tx_wr_q, tx_wr_d; // transmit bytes loaded, 0..128
  logic [7:0] rx_wr_q, rx_wr_d; // receive write pointer with wrap bit
  logic [7:0] rx_rd_q, rx_rd_d; // receive read pointer with wrap bit
  rsa_cmd_s cmd_q, cmd_d; // last committed strobe or register write
  logic cmd_tog_q; // flips once per committed command
  logic rx_avail_q; // receive buffer not empty, serial side
  logic rx_thr_q; // receive count above threshold, serial side

  // decode outputs
  logic [7:0] nxt_out; // byte to shift out next
  logic ram_we; // write one ram byte
  logic [8:0] ram_wi; // its index
  logic [7:0] ram_wv; // its value
  logic cmd_fire; // commit cmd_d
  logic [7:0] rx_cnt; // bytes waiting in the receive buffer
  logic [7:0] rx_cnt_d; // same, after this byte

  // read one ram byte, unimplemented addresses read zero
  function automatic logic [7:0] ram_rd(input logic [8:0] idx);
    ram_rd = (idx <= RSA_RAM_LAST) ? ram_q[idx] : 8'h00;
  endfunction

  assign rx_cnt = rx_wr_q - rx_rd_q;

  // byte decoder, acted on at the falling edge that ends each byte
  always_comb begin
    ph_d = ph_q;
    raddr_d = raddr_q;
    hi_d = hi_q;
    regaddr_d = regaddr_q;
    rd_d = rd_q;
    ro_d = ro_q;
    nxt_out = 8'h00;
    ram_we = 1'b0;
    ram_wi = 9'h000;
    ram_wv = sh_q;
    cmd_fire = 1'b0;
    cmd_d = cmd_q;
    tx_wr_d = tx_wr_q;
    rx_wr_d = rx_wr_q;
    rx_rd_d = rx_rd_q;
    unique case (ph_q)
      PH_ADDR: begin
        if (sh_q[RSA_AB_RAM_BIT]) begin // ram access, low address bits first
          raddr_d = {2'b00, sh_q[6:0]};
          ph_d = PH_RAM_HI;
        end else begin
          rd_d = sh_q[RSA_AB_RD_BIT];
          regaddr_d = sh_q[5:0];
          if (sh_q[5:0] <= RSA_STROBE_LAST) begin // strobe: done at this edge
            cmd_fire = 1'b1;
            cmd_d = '{is_strobe: 1'b1, addr: sh_q[5:0], data: 16'h0000};
            if (sh_q[5:0] == RSA_FLUSH_TX_CODE) begin
              tx_wr_d = 8'h00;
            end
            if (sh_q[5:0] == RSA_FLUSH_RX_CODE) begin
              rx_wr_d = 8'h00;
              rx_rd_d = 8'h00;
            end
          end else if (sh_q[5:0] == RSA_TXPORT_ADDR) begin
            ph_d = PH_TXBUF;
            nxt_out = stat_byte;
          end else if (sh_q[5:0] == RSA_RXPORT_ADDR) begin
            ph_d = PH_RXBUF;
            if (sh_q[RSA_AB_RD_BIT] && (rx_cnt != 8'h00)) begin
              nxt_out = ram_rd(RSA_RXBUF_BASE | {2'b00, rx_rd_q[6:0]});
              rx_rd_d = rx_rd_q + 8'h01;
            end
          end else begin
            ph_d = PH_REG_HI; // register map lies outside; reads return zero
          end
        end
      end
      PH_REG_HI: begin // nothing commits here, so a cut read is harmless
        hi_d = sh_q;
        ph_d = PH_REG_LO;
      end
      PH_REG_LO: begin
        if (!rd_q) begin // write commits on this last falling edge
          cmd_fire = 1'b1;
          cmd_d = '{is_strobe: 1'b0, addr: regaddr_q, data: {hi_q, sh_q}};
        end
        ph_d = PH_ADDR;
      end
      PH_RAM_HI: begin // bank select and direction
        raddr_d = {sh_q[RSA_BANK_HI:RSA_BANK_LO], raddr_q[6:0]};
        ro_d = sh_q[RSA_RAM_RO_BIT];
        ph_d = PH_RAM_DATA;
        nxt_out = ram_rd({sh_q[RSA_BANK_HI:RSA_BANK_LO], raddr_q[6:0]});
      end
      PH_RAM_DATA: begin // read+write returns old data while taking new
        ram_we = !ro_q && (raddr_q <= RSA_RAM_LAST);
        ram_wi = raddr_q;
        raddr_d = raddr_q + 9'h001;
        nxt_out = ram_rd(raddr_q + 9'h001);
      end
      PH_TXBUF: begin // write only, one byte each, overfill is dropped
        if (!rd_q && (tx_wr_q < 8'(RSA_BUF_BYTES))) begin
          ram_we = 1'b1;
          ram_wi = RSA_TXBUF_BASE | {2'b00, tx_wr_q[6:0]};
          tx_wr_d = tx_wr_q + 8'h01;
        end
        nxt_out = stat_byte;
      end
      PH_RXBUF: begin
        if (!rd_q) begin // debug or cipher staging writes
          if (rx_cnt < 8'(RSA_BUF_BYTES)) begin
            ram_we = 1'b1;
            ram_wi = RSA_RXBUF_BASE | {2'b00, rx_wr_q[6:0]};
            rx_wr_d = rx_wr_q + 8'h01;
          end
        end else if (rx_cnt != 8'h00) begin // empty buffer reads zero
          nxt_out = ram_rd(RSA_RXBUF_BASE | {2'b00, rx_rd_q[6:0]});
          rx_rd_d = rx_rd_q + 8'h01;
        end
      end
      default: begin
        ph_d = PH_ADDR; // unused code, resynchronise
      end
    endcase
  end

  assign rx_cnt_d = rx_wr_d - rx_rd_d;

  // frame decoder and output shifter on falling edges; deselect clears it
  always_ff @(negedge serial_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_q <= PH_ADDR;
      out_q <= 8'h00;
      so_q <= 1'b0; // status bit 7 is reserved zero, valid before any edge
      raddr_q <= 9'h000;
      hi_q <= 8'h00;
      regaddr_q <= 6'h00;
      rd_q <= 1'b0;
      ro_q <= 1'b0;
    end else if (got_q) begin // last falling edge of a byte
      ph_q <= ph_d;
      raddr_q <= raddr_d;
      hi_q <= hi_d;
      regaddr_q <= regaddr_d;
      rd_q <= rd_d;
      ro_q <= ro_d;
      so_q <= nxt_out[7];
      out_q <= {nxt_out[6:0], 1'b0};
    end else if ((ph_q == PH_ADDR) && (cnt_q == 3'h1)) begin
      so_q <= stat_byte[6]; // status rides every address byte
      out_q <= {stat_byte[5:0], 2'b00};
    end else begin
      so_q <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // ram contents survive reset and deselect, like the real storage
  always_ff @(negedge serial_clk) begin
    if (got_q && ram_we) begin
      ram_q[ram_wi] <= ram_wv;
    end
  end

  // buffer pointers and command handoff, kept across frames
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_wr_q <= 8'h00;
      rx_wr_q <= 8'h00;
      rx_rd_q <= 8'h00;
      cmd_q <= '0;
      cmd_tog_q <= 1'b0;
      rx_avail_q <= 1'b0;
      rx_thr_q <= 1'b0;
    end else if (got_q) begin
      tx_wr_q <= tx_wr_d;
      rx_wr_q <= rx_wr_d;
      rx_rd_q <= rx_rd_d;
      rx_avail_q <= (rx_cnt_d != 8'h00); // from next value: clock may stop
      rx_thr_q <= (rx_cnt_d > RX_THRESHOLD);
      if (cmd_fire) begin // cmd_q holds still until the next commit
        cmd_q <= cmd_d;
        cmd_tog_q <= ~cmd_tog_q;
      end
    end
  end

  assign serial_out = so_q;

  // -------------------------------------------------------------- core domain
  logic cs_s1_q, cs_s2_q, cs_s3_q; // select synchroniser
  logic oe_q; // serial output enable
  logic tg_s1_q, tg_s2_q, tg_s3_q; // command toggle synchroniser
  logic tg_seen_q; // last toggle level acted upon
  logic ra_s1_q, ra_s2_q, ra_s3_q; // rx available synchroniser
  logic rt_s1_q, rt_s2_q, rt_s3_q; // rx threshold synchroniser
  logic rx_avail_pin_q, rx_thr_pin_q; // buffer status pins
  logic strobe_pulse_q, reg_wr_pulse_q; // event pulses
  logic [5:0] strobe_code_q, reg_addr_q; // event codes
  logic [15:0] reg_wdata_q; // register write data
  logic cmd_evt; // a new command has arrived
  logic tx_flush_evt; // that command is the transmit flush

  // the three-flop chains; the first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      ra_s1_q <= 1'b0;
      ra_s2_q <= 1'b0;
      ra_s3_q <= 1'b0;
      rt_s1_q <= 1'b0;
      rt_s2_q <= 1'b0;
      rt_s3_q <= 1'b0;
    end else begin
      cs_s1_q <= serial_select_low;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tg_s1_q <= cmd_tog_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      ra_s1_q <= rx_avail_q;
      ra_s2_q <= ra_s1_q;
      ra_s3_q <= ra_s2_q;
      rt_s1_q <= rx_thr_q;
      rt_s2_q <= rt_s1_q;
      rt_s3_q <= rt_s2_q;
    end
  end

  // output enable follows select; the late start only costs reserved bit 7
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (cs_s2_q == cs_s3_q) begin
      oe_q <= ~cs_s3_q;
    end
  end

  // buffer pins reflect only the receive buffer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_avail_pin_q <= 1'b0;
      rx_thr_pin_q <= 1'b0;
    end else begin
      if (ra_s2_q == ra_s3_q) begin
        rx_avail_pin_q <= ra_s3_q;
      end
      if (rt_s2_q == rt_s3_q) begin
        rx_thr_pin_q <= rt_s3_q;
      end
    end
  end

  assign cmd_evt = (tg_s2_q == tg_s3_q) && (tg_s3_q != tg_seen_q);
  assign tx_flush_evt = cmd_evt && cmd_q.is_strobe && (cmd_q.addr == RSA_FLUSH_TX_CODE);

  // commands reach the core one ref cycle each; cmd_q is stable by now
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tg_seen_q <= 1'b0;
      strobe_pulse_q <= 1'b0;
      reg_wr_pulse_q <= 1'b0;
      strobe_code_q <= 6'h00;
      reg_addr_q <= 6'h00;
      reg_wdata_q <= 16'h0000;
    end else begin
      strobe_pulse_q <= cmd_evt && cmd_q.is_strobe;
      reg_wr_pulse_q <= cmd_evt && !cmd_q.is_strobe;
      if (cmd_evt) begin
        tg_seen_q <= tg_s3_q;
        if (cmd_q.is_strobe) begin
          strobe_code_q <= cmd_q.addr;
        end else begin
          reg_addr_q <= cmd_q.addr;
          reg_wdata_q <= cmd_q.data;
        end
      end
    end
  end

  // underflow sticks until transmit flush; a new underflow beats the clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_underflow_q <= 1'b0;
    end else if (tx_underflow_evt) begin
      tx_underflow_q <= 1'b1;
    end else if (tx_flush_evt) begin
      tx_underflow_q <= 1'b0;
    end
  end

  assign serial_out_oe = oe_q;
  assign strobe_pulse = strobe_pulse_q;
  assign strobe_code = strobe_code_q;
  assign reg_wr_pulse = reg_wr_pulse_q;
  assign reg_addr = reg_addr_q;
  assign reg_wdata = reg_wdata_q;
  assign tx_underflow = tx_underflow_q;
  assign rx_avail_pin = rx_avail_pin_q;
  assign rx_threshold_pin = rx_thr_pin_q;

endmodule // rsa_serial_access

// File: rsa_serial_access_properties.sv
// Purpose: port-level assertions for the serial access block
// Assumes: every check runs on the core clock
// Notes: bound to each instance of the design
`timescale 1ns/1ps
module rsa_serial_access_chk
  import rsa_pkg::*;
#(
  parameter logic [7:0] RX_THRESHOLD = 8'h40 // same threshold as the design
) (
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // reset, active low
  input wire logic serial_select_low, // host select
  input wire logic serial_out_oe, // output enable
  input wire logic tx_underflow_evt, // underflow pulse
  input wire logic strobe_pulse, // strobe executed
  input wire logic [5:0] strobe_code, // last strobe
  input wire logic reg_wr_pulse, // register write done
  input wire logic tx_underflow, // sticky flag
  input wire logic rx_avail_pin, // receive data held
  input wire logic rx_threshold_pin // receive count high
);
  // single domain, so clock and reset are given once
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_uf_set: assert property (
    tx_underflow_evt |=> tx_underflow) else $error("underflow flag not set");
  chk_uf_rise: assert property (
    $rose(tx_underflow) |-> $past(tx_underflow_evt)) else $error("underflow set without event");
  chk_uf_clear: assert property (
    $fell(tx_underflow) |-> strobe_pulse && strobe_code == RSA_FLUSH_TX_CODE)
    else $error("underflow cleared without flush");
  chk_strobe_one: assert property (
    strobe_pulse |=> !strobe_pulse) else $error("strobe pulse too long");
  chk_write_one: assert property (
    reg_wr_pulse |=> !reg_wr_pulse) else $error("write pulse too long");
  chk_strobe_range: assert property (
    strobe_pulse |-> strobe_code <= RSA_STROBE_LAST) else $error("strobe code out of range");
  chk_rx_flush: assert property (
    strobe_pulse && strobe_code == RSA_FLUSH_RX_CODE |-> ##[0:8] !rx_avail_pin)
    else $error("receive buffer not emptied");
  chk_thr_avail: assert property (
    rx_threshold_pin |-> rx_avail_pin) else $error("threshold without data");
  chk_oe_on: assert property (
    $fell(serial_select_low) |-> ##[1:6] serial_out_oe) else $error("output not enabled");
  chk_oe_off: assert property (
    serial_select_low [*6] |-> !serial_out_oe) else $error("output driven while idle");

  // main scenarios reached
  cov_flush_tx: cover property ($fell(tx_underflow));
  cov_reg_wr: cover property (reg_wr_pulse);
  cov_thr: cover property (rx_threshold_pin);
endmodule // rsa_serial_access_chk

bind rsa_serial_access rsa_serial_access_chk #(.RX_THRESHOLD(RX_THRESHOLD)) u_chk (
  .ref_clk, .rst_n, .serial_select_low, .serial_out_oe, .tx_underflow_evt, .strobe_pulse,
  .strobe_code, .reg_wr_pulse, .tx_underflow, .rx_avail_pin, .rx_threshold_pin);

// File: rsa_serial_access_tb_top.sv
// Purpose: self-checking bench for the serial access block
// Assumes: host model drives the link, bench drives core-side inputs
// Notes: pulses are counted, levels compared after settling
`timescale 1ns/1ps
module rsa_serial_access_tb_top;
  import rsa_pkg::*;
  logic ref_clk = 1'b0; // core clock
  logic rst_n = 1'b0; // reset, active low
  logic serial_clk, serial_select_low, serial_in, serial_out, serial_out_oe; // link
  rsa_radio_s radio_in; // radio levels
  logic tx_underflow_evt, strobe_pulse, reg_wr_pulse, tx_underflow; // core side
  logic rx_avail_pin, rx_threshold_pin; // receive pins
  logic [5:0] strobe_code, reg_addr; // last command
  logic [15:0] reg_wdata; // last write data
  logic [7:0] r; // last byte from the device
  int n_mismatch = 0, n_compared = 0, n_wr = 0, n_str = 0; // counters

  rsa_host_model u_rsa_host_model (.serial_clk, .serial_select_low, .serial_in, .serial_out,
    .serial_out_oe);
  rsa_serial_access #(.RX_THRESHOLD(8'h01)) u_rsa_serial_access (.ref_clk, .rst_n,
    .serial_clk, .serial_select_low, .serial_in, .serial_out, .serial_out_oe, .radio_in,
    .tx_underflow_evt, .strobe_pulse, .strobe_code, .reg_wr_pulse, .reg_addr, .reg_wdata,
    .tx_underflow, .rx_avail_pin, .rx_threshold_pin);

  // 100 mhz core clock
  always #5 ref_clk = ~ref_clk;
  // count one-cycle pulses, they pass while the host is busy
  always @(negedge ref_clk) begin
    if (reg_wr_pulse === 1'b1) n_wr++;
    if (strobe_pulse === 1'b1) n_str++;
  end

  task automatic end_of_test();
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic sel(); u_rsa_host_model.sel(); endtask
  task automatic desel(); u_rsa_host_model.desel(); endtask
  task automatic xb(input logic [7:0] t); u_rsa_host_model.xfer(t, r); endtask
  // ram address bytes: bank in the second byte, then direction
  task automatic ram_open(input logic [8:0] a, input logic ro);
    sel();
    xb({1'b1, a[6:0]});
    xb({a[8:7], ro, 5'h00});
  endtask

  // underflow shows in the status byte until the flush strobe
  task automatic t_underflow();
    int s;
    @(negedge ref_clk) tx_underflow_evt = 1'b1;
    @(negedge ref_clk) tx_underflow_evt = 1'b0;
    chk(tx_underflow, 1'b1);
    chk(rx_avail_pin, 1'b0);
    sel();
    xb(8'h00);
    xb(8'h00);
    chk(r, 8'h6c);
    settle(10);
    s = n_str;
    xb({2'b00, RSA_FLUSH_TX_CODE});
    settle(10);
    chk(n_str, s + 1);
    desel();
    chk(tx_underflow, 1'b0);
    chk(strobe_code, RSA_FLUSH_TX_CODE);
  endtask
  // register write chained with a strobe in one frame
  task automatic t_reg();
    int s = n_wr;
    sel();
    xb(8'h15);
    xb(8'h12);
    xb(8'h34);
    xb({2'b00, RSA_FLUSH_RX_CODE});
    desel();
    settle(10);
    chk(n_wr, s + 1);
    chk(reg_addr, 6'h15);
    chk(reg_wdata, 16'h1234);
    chk(strobe_code, RSA_FLUSH_RX_CODE);
  endtask
  // read and write cut after the upper byte commit nothing
  task automatic t_trunc();
    int s = n_wr;
    sel();
    xb(8'h55);
    xb(8'h00);
    desel();
    sel();
    xb(8'h15);
    xb(8'hff);
    desel();
    settle(10);
    chk(n_wr, s);
    chk(reg_wdata, 16'h1234);
  endtask
  // frames go in through the port only, ram path reads them back
  task automatic t_txload();
    sel();
    xb(RSA_TXPORT_ADDR);
    for (int i = 0; i < 3; i++) begin
      xb(8'ha0 + i);
      chk(r, 8'h4c);
    end
    desel();
    sel();
    xb(8'h7e);
    xb(8'h00);
    chk(r, 8'h4c);
    desel();
    ram_open(RSA_TXBUF_BASE, 1'b1);
    for (int i = 0; i < 3; i++) begin
      xb(8'h00);
      chk(r, 8'ha0 + i);
    end
    desel();
  endtask
  // receive port written, checked via ram and port, then flushed
  task automatic t_rx();
    sel();
    xb(RSA_RXPORT_ADDR);
    xb(8'h5a);
    xb(8'ha5);
    desel();
    settle(10);
    chk(rx_avail_pin, 1'b1);
    chk(rx_threshold_pin, 1'b1);
    ram_open(RSA_RXBUF_BASE, 1'b1);
    xb(8'h00);
    chk(r, 8'h5a);
    desel();
    sel();
    xb(8'h7f);
    xb(8'h00);
    chk(r, 8'h5a);
    xb(8'h00);
    chk(r, 8'ha5);
    desel();
    settle(10);
    chk(rx_avail_pin, 1'b0);
    sel();
    xb(RSA_RXPORT_ADDR);
    xb(8'h11);
    desel();
    sel();
    xb({2'b00, RSA_FLUSH_RX_CODE});
    desel();
    settle(10);
    chk(rx_avail_pin, 1'b0);
  endtask
  // security bank areas written then read back; read-only pass stores nothing
  task automatic t_ram();
    logic [8:0] a [8] = '{9'h100, 9'h120, 9'h130, 9'h140, 9'h150, 9'h160, 9'h168, 9'h16a};
    foreach (a[i]) begin
      ram_open(a[i], 1'b0);
      xb(a[i][7:0]);
      xb(~a[i][7:0]);
      desel();
    end
    ram_open(RSA_STANDALONE_CIPHER_BUFFER_BASE, 1'b1);
    xb(8'hff);
    desel();
    foreach (a[i]) begin
      ram_open(a[i], 1'b1);
      xb(8'h00);
      chk(r, a[i][7:0]);
      xb(8'h00);
      chk(r, 8'(~a[i][7:0]));
      desel();
    end
  endtask

  // oscillator reported running before any buffer access
  initial begin
    radio_in = 5'b10110;
    tx_underflow_evt = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    settle(4);
    t_underflow();
    t_reg();
    t_trunc();
    t_txload();
    t_rx();
    t_ram();
    end_of_test();
  end
  // the run needs some 16 us, far below this limit
  initial begin
    #200000;
    n_mismatch++;
    end_of_test();
  end
endmodule // rsa_serial_access_tb_top
